// [testbench/ppm_mem.sv]
`default_nettype none
module ppm_mem
  import ppm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic [71:0] pin_o,
  input wire logic [71:0] pin_oe_o,
  input wire logic strobe_n_i,
  input wire logic [3:0] wait_i,
  output logic [71:0] drv_o,
  output logic [71:0] drv_en_o,
  output logic [23:0] addr_o,
  output logic [15:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic [23:0] a_q;
  // address taken while strobe high, data only while low
  always_ff @(posedge mclk_i) begin
    if (strobe_n_i) begin
      cnt_q <= 4'h0;
      if (pin_oe_o[7:0] == 8'hFF) a_q <= pin_o[23:0];
    end else begin
      if (cnt_q == 4'h0) addr_o <= a_q;
      if (cnt_q != 4'hF) cnt_q <= cnt_q + 4'h1;
      if (pin_oe_o[16]) wdata_o <= {pin_o[15:8], pin_o[23:16]};
    end
  end
  // read data and ready only in the data phase; hold request kept low
  always_comb begin
    drv_o = 72'h0;
    drv_en_o = 72'h0;
    drv_en_o[33:32] = 2'h3;
    drv_o[33] = !strobe_n_i && (cnt_q >= wait_i);
    drv_en_o[23:8] = {16{!strobe_n_i}};
    drv_o[23:8] = {a_q[7:0], ~a_q[7:0]};
  end
endmodule : ppm_mem
`default_nettype wire

// [testbench/tb_ppm_mux.sv]
`default_nettype none
module tb_ppm_mux
  import ppm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, msel = 1'b0, micro = 1'b0, width = 1'b0;
  logic req = 1'b0, wr = 1'b0, byte_hi = 1'b1, clk_en = 1'b0, dir_we = 1'b0;
  logic [23:0] addr = 24'h0, m_addr;
  logic [15:0] wdata = 16'h0, rdata, m_wdata, rd;
  logic [71:0] dir = 72'h0, pin_i, pin_o, pin_oe, drv, drv_en;
  logic [3:0] wait_c = 4'h0;
  logic strobe_n, done, hold_rq;
  logic [71:0] port_in;
  logic [2:0] mode;
  int n_errors = 0, comparisons = 0, cyc = 0;
  always #4 mclk_i = ~mclk_i;
  // Undriven pins toggle so a stale value never looks valid
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & drv_en & drv) | (~pin_oe & ~drv_en & {72{cyc[0]}});
  ppm_mux u_ppm_mux (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .mode_select_pin_i(msel),
    .micro_mode_req_i(micro), .bus_width_pin_i(width), .bus_req_i(req), .bus_write_i(wr),
    .bus_addr_i(addr), .bus_wdata_i(wdata), .bus_byte_hi_i(byte_hi), .hold_ack_i(1'b0),
    .clk_out_en_i(clk_en), .bus_rdata_o(rdata), .bus_done_o(done), .hold_req_o(hold_rq),
    .port_out_i(72'h0), .port_dir_i(dir), .port_dir_we_i(dir_we), .alt_out_i(32'h0),
    .alt_oe_i(32'h0), .port_in_o(port_in), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe),
    .enable_strobe_n_o(strobe_n), .mode_o(mode));
  ppm_mem u_ppm_mem (.mclk_i(mclk_i), .pin_o(pin_o), .pin_oe_o(pin_oe), .strobe_n_i(strobe_n),
    .wait_i(wait_c), .drv_o(drv), .drv_en_o(drv_en), .addr_o(m_addr), .wdata_o(m_wdata));
  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  // Request held until done is seen, released at the next falling edge
  task automatic bus_op(input logic w, input logic [23:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge mclk_i);
    {req, wr, addr, wdata} = {1'b1, w, a, d};
    @(posedge mclk_i);
    #1;
    while (done !== 1'b1 && n < 60) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    rd = rdata;
    check(n < 60, 1'b1);
    @(negedge mclk_i);
    req = 1'b0;
  endtask : bus_op
  task automatic set_mode(input logic m, input logic u, input logic b);
    @(negedge mclk_i);
    {msel, micro, width} = {m, u, b};
    repeat (6) @(negedge mclk_i);
  endtask : set_mode
  task automatic t_reset();
    check(pin_oe, 72'h0);
    check(strobe_n, 1'b1);
    check(mode, PPM_SINGLE);
    $display("test reset done");
  endtask : t_reset
  task automatic t_single();
    int seen;
    seen = 0;
    @(negedge mclk_i);
    {dir[7:0], dir_we} = {8'hA5, 1'b1};
    @(negedge mclk_i);
    dir_we = 1'b0;
    repeat (3) @(negedge mclk_i);
    check(pin_oe[7:0], 8'hA5);
    {req, addr} = {1'b1, 24'h000123};
    repeat (20) begin
      @(posedge mclk_i);
      #1;
      if (done !== 1'b0 || strobe_n !== 1'b1) seen++;
    end
    check(seen, 0);
    check(port_in[7:0] & 8'hA5, 8'h00);
    @(negedge mclk_i);
    req = 1'b0;
    $display("test single done");
  endtask : t_single
  task automatic t_expand();
    set_mode(1'b1, 1'b0, 1'b0);
    clk_en = 1'b1;
    check(mode, PPM_EXPAND);
    repeat (3) @(negedge mclk_i);
    check(pin_oe[34], 1'b1);
    check({pin_oe[33:32], pin_oe[27:24]}, 6'h0F);
    wait_c = 4'h3;
    bus_op(1'b0, 24'h3C5A96, 16'h0);
    check(rd, 16'h6996);
    check(m_addr, 24'h3C5A96);
    wait_c = 4'h0;
    bus_op(1'b1, 24'h01F00E, 16'hBEEF);
    check(m_wdata, 16'hBEEF);
    check(hold_rq, 1'b0);
    $display("test expand done");
  endtask : t_expand
  task automatic t_byte();
    set_mode(1'b1, 1'b0, 1'b1);
    bus_op(1'b0, 24'h7E2C41, 16'h0);
    check(rd, 16'h0041);
    check(m_addr, 24'h7E2C41);
    $display("test byte done");
  endtask : t_byte
  task automatic t_micro();
    clk_en = 1'b0;
    set_mode(1'b1, 1'b1, 1'b0);
    repeat (3) @(negedge mclk_i);
    check(mode, PPM_MICRO);
    check(pin_oe[34], 1'b1);
    $display("test micro done");
  endtask : t_micro
  // Hang guard well beyond the expected run length
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    // reset held low for eight cycles
    repeat (8) @(negedge mclk_i);
    t_reset();
    rst_n_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    t_single();
    t_expand();
    t_byte();
    t_micro();
    print_verdict();
  end
endmodule : tb_ppm_mux
`default_nettype wire

// [verilog/ppm_mux.sv]
`default_nettype none
module ppm_mux
  import ppm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Straps from pins
  input wire logic mode_select_pin_i,
  input wire logic micro_mode_req_i,
  input wire logic bus_width_pin_i,
  // Core bus request
  input wire logic bus_req_i,
  input wire logic bus_write_i,
  input wire logic [23:0] bus_addr_i,
  input wire logic [15:0] bus_wdata_i,
  input wire logic bus_byte_hi_i,
  input wire logic hold_ack_i,
  input wire logic clk_out_en_i,
  output logic [15:0] bus_rdata_o,
  output logic bus_done_o,
  output logic hold_req_o,
  // General port registers from the core
  input wire logic [71:0] port_out_i,
  input wire logic [71:0] port_dir_i,
  input wire logic port_dir_we_i,
  // Peripheral alternate outputs, one byte per port five..eight; the port seven byte is ignored
  input wire logic [31:0] alt_out_i,
  input wire logic [31:0] alt_oe_i,
  output logic [71:0] port_in_o,
  // Pins
  input wire logic [71:0] pin_i,
  output logic [71:0] pin_o,
  output logic [71:0] pin_oe_o,
  output logic enable_strobe_n_o,
  output logic [2:0] mode_o
);

  logic [71:0] pin_s1_q;
  logic [71:0] pin_s2_q;
  logic [2:0] strap_s1_q;
  logic [2:0] strap_s2_q;
  logic [71:0] dir_q;
  ppm_mode_e mode_q;
  logic wide_q;
  logic div_q;
  logic phase_q;
  logic active_q;
  logic [71:0] pin_d;
  logic [71:0] oe_d;

  function automatic logic [7:0] port_byte(input logic [71:0] v, input int n);
    port_byte = v[n*8 +: 8];
  endfunction : port_byte

  // Bus modes share one decode so the pin mux and hold logic never disagree
  function automatic logic bus_mode(input ppm_mode_e m);
    bus_mode = (m != PPM_SINGLE);
  endfunction : bus_mode

  // Two stage sync of every pin and strap; stage one feeds only stage two
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      strap_s1_q <= '0;
      strap_s2_q <= '0;
    end else begin
      pin_s1_q <= pin_i;
      pin_s2_q <= pin_s1_q;
      strap_s1_q <= {bus_width_pin_i, micro_mode_req_i, mode_select_pin_i};
      strap_s2_q <= strap_s1_q;
    end
  end

  // Mode follows the synced straps every cycle after release; held in single-chip during reset
  // reset entry
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q <= PPM_SINGLE;
    end else if (!strap_s2_q[0]) begin
      mode_q <= PPM_SINGLE;
    end else if (strap_s2_q[1]) begin
      mode_q <= PPM_MICRO;
    end else begin
      mode_q <= PPM_EXPAND;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wide_q <= 1'b0;
    end else begin
      wide_q <= !strap_s2_q[2];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dir_q <= {9{PPM_DIR_RST}};
    end else if (port_dir_we_i) begin
      dir_q <= port_dir_i;
    end
  end

  // Clock divided by two for the clock output pin
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q <= 1'b0;
    end else begin
      div_q <= !div_q;
    end
  end

  // Two phase access: address with strobe high, then data with strobe low
  // strobe framing
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active_q <= 1'b0;
      phase_q <= 1'b0;
    end else if (mode_q == PPM_SINGLE || hold_ack_i) begin
      active_q <= 1'b0;
      phase_q <= 1'b0;
    end else if (!active_q && bus_req_i) begin
      active_q <= 1'b1;
      phase_q <= 1'b0;
    end else if (active_q && !phase_q) begin
      phase_q <= 1'b1;
    end else if (active_q && phase_q && pin_s2_q[4*8+PPM_P4_RDY]) begin
      active_q <= 1'b0;
      phase_q <= 1'b0;
    end
  end

  // Pin drive per mode
  always_comb begin
    logic bus;
    logic dat;
    bus = bus_mode(mode_q);
    dat = active_q && phase_q;
    pin_d = port_out_i;
    oe_d = dir_q;
    if (bus) begin
      pin_d[7:0] = bus_addr_i[7:0];
      oe_d[7:0] = 8'hFF;
      if (wide_q && dat) begin
        pin_d[15:8] = bus_wdata_i[15:8];
        oe_d[15:8] = {8{bus_write_i}};
      end else begin
        pin_d[15:8] = bus_addr_i[15:8];
        oe_d[15:8] = 8'hFF;
      end
      if (dat) begin
        pin_d[23:16] = bus_wdata_i[7:0];
        oe_d[23:16] = {8{bus_write_i}};
      end else begin
        pin_d[23:16] = bus_addr_i[23:16];
        oe_d[23:16] = 8'hFF;
      end
      pin_d[24+PPM_P3_RW] = !(active_q && bus_write_i);
      pin_d[24+PPM_P3_BHE] = !(active_q && bus_byte_hi_i && wide_q);
      pin_d[24+PPM_P3_ALE] = active_q && !phase_q;
      pin_d[24+PPM_P3_HOLD_ACKNOWLEDGE] = hold_ack_i;
      oe_d[31:24] = {4'h0, 4'hF};
      oe_d[32+PPM_P4_HOLD] = 1'b0;
      oe_d[32+PPM_P4_RDY] = 1'b0;
    end
    if (mode_q == PPM_MICRO || clk_out_en_i) begin
      pin_d[32+PPM_P4_CLK] = div_q;
      oe_d[32+PPM_P4_CLK] = 1'b1;
    end
    for (int p = 0; p < 4; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (alt_oe_i[p*8+b]) begin
          pin_d[40+p*8+b] = alt_out_i[p*8+b];
          oe_d[40+p*8+b] = 1'b1;
        end
      end
    end
    // analog pins never driven by alternates
    oe_d[63:56] = dir_q[63:56];
    pin_d[63:56] = port_out_i[63:56];
  end

  // Registered pins and strobe
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_o <= '0;
      pin_oe_o <= '0;
      enable_strobe_n_o <= 1'b1;
      mode_o <= PPM_SINGLE;
    end else begin
      pin_o <= pin_d;
      pin_oe_o <= oe_d;
      enable_strobe_n_o <= !(active_q && phase_q);
      mode_o <= mode_q;
    end
  end

  // Read data captured at end of strobe-low phase
  // data while low
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_rdata_o <= '0;
      bus_done_o <= 1'b0;
      hold_req_o <= 1'b0;
      port_in_o <= '0;
    end else begin
      bus_done_o <= active_q && phase_q && pin_s2_q[4*8+PPM_P4_RDY];
      if (active_q && phase_q && pin_s2_q[4*8+PPM_P4_RDY]) begin
        bus_rdata_o <= wide_q ? {port_byte(pin_s2_q, 1), port_byte(pin_s2_q, 2)}
                              : {8'h00, port_byte(pin_s2_q, 2)};
      end
      hold_req_o <= bus_mode(mode_q) && pin_s2_q[4*8+PPM_P4_HOLD];
      port_in_o <= pin_s2_q;
    end
  end

  // Pin checks look one edge back because every pin output is registered;
  // a check on the current state would be a cycle early and fire falsely.

  chk_strobe_single_idle: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    $past(mode_q) == PPM_SINGLE |-> enable_strobe_n_o)
    else $error("strobe low in single-chip mode");

  chk_micro_clock: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    $past(mode_q) == PPM_MICRO |-> pin_oe_o[32+PPM_P4_CLK])
    else $error("clock pin not driven in micro mode");

  chk_done_strobe_low: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    bus_done_o |-> !enable_strobe_n_o)
    else $error("access finished outside strobe low");

  chk_port_zero_addr: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    $past(mode_q) != PPM_SINGLE |-> pin_oe_o[7:0] == 8'hFF)
    else $error("port zero not driving address");

  chk_hold_ready_inputs: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    $past(mode_q) != PPM_SINGLE |-> pin_oe_o[33:32] == 2'h0)
    else $error("hold or ready pin driven in bus mode");

  chk_byte_port_one: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    $past(mode_q) != PPM_SINGLE && !$past(wide_q) |-> pin_oe_o[15:8] == 8'hFF)
    else $error("port one not address on narrow bus");

  chk_wide_addr_phase: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    $past(mode_q) != PPM_SINGLE && !$past(active_q && phase_q) |-> pin_oe_o[15:8] == 8'hFF)
    else $error("port one not address while strobe high");

  chk_ale_addr_phase: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    $past(mode_q) != PPM_SINGLE && pin_o[24+PPM_P3_ALE] |-> enable_strobe_n_o)
    else $error("latch enable during data phase");

  chk_read_data_float: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    !enable_strobe_n_o && !$past(bus_write_i) |-> pin_oe_o[23:16] == 8'h00)
    else $error("port two driven during read data phase");

  chk_narrow_read_data: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    bus_done_o && !$past(wide_q) |-> bus_rdata_o[15:8] == 8'h00)
    else $error("high read byte set on narrow bus");

  chk_clock_pin_enable: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    $past(clk_out_en_i) |-> pin_oe_o[32+PPM_P4_CLK])
    else $error("clock pin not driven when enabled");

  chk_single_port_dir: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    $past(mode_q) == PPM_SINGLE |-> pin_oe_o[7:0] == $past(dir_q[7:0]))
    else $error("port zero enable differs from direction bits");

  chk_control_pins_out: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    $past(mode_q) != PPM_SINGLE |-> pin_oe_o[27:24] == 4'hF)
    else $error("port three controls not driven");

  chk_single_hold_low: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    $past(mode_q) == PPM_SINGLE |-> !hold_req_o)
    else $error("hold request raised in single-chip mode");

  chk_mode_output_match: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    mode_o == $past(mode_q))
    else $error("mode output differs from mode state");

endmodule : ppm_mux
`default_nettype wire

// [verilog/ppm_pkg.sv]
`default_nettype none
package ppm_pkg;
  // Processor modes
  typedef enum logic [2:0] {
    PPM_SINGLE = 3'h1,
    PPM_EXPAND = 3'h2,
    PPM_MICRO = 3'h4
  } ppm_mode_e;
  // Port widths and reset values
  localparam int PPM_PORT_W = 8;
  localparam int PPM_P3_W = 4;
  localparam logic [7:0] PPM_DIR_RST = 8'h00;
  // Port three pin positions in bus modes
  localparam int PPM_P3_RW = 0;
  localparam int PPM_P3_BHE = 1;
  localparam int PPM_P3_ALE = 2;
  localparam int PPM_P3_HOLD_ACKNOWLEDGE = 3;
  // Port four pin positions
  localparam int PPM_P4_HOLD = 0;
  localparam int PPM_P4_RDY = 1;
  localparam int PPM_P4_CLK = 2;
  // Pulse motor pins on port five and six
  localparam logic [7:0] PPM_P5_PM_MASK = 8'h7F;
  localparam logic [7:0] PPM_P6_PM_MASK = 8'h01;
  localparam int PPM_P7_TRIG = 7;
endpackage : ppm_pkg
`default_nettype wire
